//--- src/sqtim_pkg.sv
// constants shared by the sequencer and crt timing block
package sqtim_pkg;
  // host i/o port addresses
  localparam logic [15:0] SEQ_INDEX_PORT  = 16'h03c4;
  localparam logic [15:0] SEQ_DATA_PORT   = 16'h03c5;
  localparam logic [15:0] MISC_WR_PORT    = 16'h03c2;
  localparam logic [15:0] MISC_RD_PORT    = 16'h03cc;
  localparam logic [15:0] CRTC_MONO_INDEX = 16'h03b4;
  localparam logic [15:0] CRTC_MONO_DATA  = 16'h03b5;
  localparam logic [15:0] CRTC_COLR_INDEX = 16'h03d4;
  localparam logic [15:0] CRTC_COLR_DATA  = 16'h03d5;
  // sequencer indices
  localparam logic [2:0] SEQ_IX_RESET    = 3'h0;
  localparam logic [2:0] SEQ_IX_CLK_MODE = 3'h1;
  // crt controller indices
  localparam logic [4:0] CR_HTOTAL     = 5'h00;
  localparam logic [4:0] CR_HDISP_END  = 5'h01;
  localparam logic [4:0] CR_HBLANK_ST  = 5'h02;
  localparam logic [4:0] CR_HBLANK_END = 5'h03;
  localparam logic [4:0] CR_HRET_ST    = 5'h04;
  localparam logic [4:0] CR_HRET_END   = 5'h05;
  localparam logic [4:0] CR_VTOTAL     = 5'h06;
  localparam logic [4:0] CR_OVERFLOW   = 5'h07;
  localparam logic [4:0] CR_ROW_PRESET = 5'h08;
  localparam logic [4:0] CR_MAX_SCAN   = 5'h09;
  localparam int         CR_COUNT      = 10;
  // field positions
  localparam int RST_ASYNC_BIT = 0;
  localparam int RST_SYNC_BIT  = 1;
  localparam int CM_EIGHT_BIT  = 0;
  localparam int CM_LOAD2_BIT  = 2;
  localparam int CM_HALF_BIT   = 3;
  localparam int CM_LOAD4_BIT  = 4;
  localparam int CM_OFF_BIT    = 5;
  localparam int MISC_COLR_BIT = 0;
  localparam int OV_VT8_BIT    = 0;
  localparam int OV_VT9_BIT    = 5;
  localparam int HRE_HBE5_BIT  = 7;
  // masks of implemented bits; reserved bits read zero
  localparam logic [7:0] SEQ_IX_MASK  = 8'h07;
  localparam logic [7:0] RST_MASK     = 8'h03;
  localparam logic [7:0] CM_MASK      = 8'h3d;
  localparam logic [7:0] CRTC_IX_MASK = 8'h3f;
  localparam logic [7:0] RESET_VALUE  = 8'h00;
  // timing figures
  localparam logic [3:0] DOT_LAST_8 = 4'h7;
  localparam logic [3:0] DOT_LAST_9 = 4'h8;
  localparam logic [8:0] HTOTAL_ADJ = 9'h004;
  localparam logic [9:0] VTOTAL_ADJ = 10'h001;
  localparam logic [7:0] LINE_GFX_LO = 8'hc0;
  localparam logic [7:0] LINE_GFX_HI = 8'hdf;
endpackage

//--- src/sqtim_clk_if.sv
// character clock enables passed from the sequencer to the crt timing
`timescale 1ns/1ps
`default_nettype none
interface sqtim_clk_if;
  logic       dot_en;
  logic       char_en;
  logic       load_en;
  logic [3:0] dot_idx;
  modport gen (output dot_en, output char_en, output load_en, output dot_idx);
  modport sink (input dot_en, input char_en, input load_en, input dot_idx);
endinterface
`default_nettype wire

//--- src/sqtim_dotgen.sv
// sequencer dot and character clock enable generator
`timescale 1ns/1ps
`default_nettype none
module sqtim_dotgen (
  // clock and resets
  input  wire logic mclk,
  input  wire logic arst,
  input  wire logic sync_halt,
  // clocking mode
  input  wire logic eight_dot,
  input  wire logic half_dot,
  input  wire logic load2,
  input  wire logic load4,
  // enables out
  sqtim_clk_if.gen  ck
);
  typedef struct packed {
    logic       half;
    logic [3:0] dot;
    logic [1:0] chr;
  } sqtim_gen_t;
  sqtim_gen_t st_reg, st_next;
  logic       tick;
  logic [3:0] last;

  // halved dot rate skips every other master clock; an async halt gates it too
  assign tick = ~arst & ~sync_halt & (~half_dot | st_reg.half);
  assign last = eight_dot ? sqtim_pkg::DOT_LAST_8 : sqtim_pkg::DOT_LAST_9;
  assign ck.dot_en  = tick;
  assign ck.char_en = tick & (st_reg.dot == last);
  assign ck.dot_idx = st_reg.dot;
  // serializer reload rate: every, every second or every fourth char
  assign ck.load_en = ck.char_en & (load4 ? (st_reg.chr == 2'h3) :
                                    load2 ? st_reg.chr[0] : 1'b1);

  // counters; a synchronous halt clears them in place
  always_comb begin
    st_next = st_reg;
    if (sync_halt) begin
      st_next = '0;
    end else begin
      st_next.half = ~st_reg.half;
      if (tick) begin
        st_next.dot = (st_reg.dot == last) ? 4'h0 : st_reg.dot + 4'h1;
        if (st_reg.dot == last) begin
          st_next.chr = st_reg.chr + 2'h1;
        end
      end
    end
  end

  // async clear also comes from the control register bit
  always_ff @(posedge mclk or posedge arst) begin
    if (arst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // sqtim_dotgen
`default_nettype wire

//--- src/sqtim_skew.sv
// programmable character clock skew of a timing signal
`timescale 1ns/1ps
`default_nettype none
module sqtim_skew #(
  parameter int DEPTH = 3
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // signal and skew
  input  wire logic       adv,
  input  wire logic [1:0] skew,
  input  wire logic       d,
  output logic            q
);
  typedef struct packed {
    logic [DEPTH-1:0] tap;
  } sqtim_skew_t;
  sqtim_skew_t st_reg, st_next;

  // zero skew passes the registered source straight through
  always_comb begin
    q = (skew == 2'h0) ? d : st_reg.tap[skew - 2'h1];
  end

  // one tap per character clock
  always_comb begin
    st_next = st_reg;
    if (adv) begin
      st_next.tap = {st_reg.tap[DEPTH-2:0], d};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // sqtim_skew
`default_nettype wire

//--- src/sqtim_top.sv
// sequencer clocking and crt horizontal timing with host i/o registers
//
// Contract
// - reset bit0 low clears sequencer asynchronously
// - reset bit1 low clears sequencer synchronously
// - sequencer runs only with both bits set
// - clocking bit0 picks nine or eight dots
// - ninth dot copies eighth for C0-DF
// - bit2 reloads serializers every second char
// - bit3 divides master clock by two
// - bit4 reloads serializers every fourth char
// - bit5 blanks screen for host bandwidth
// - crtc ports follow misc output bit0
// - index low five bits select crtc register
// - horizontal total is five less than period
// - display end field is characters minus one
// - blanking starts at programmed start value
// - blanking ends on six-bit end match
// - display enable skew zero to three
// - retrace starts at programmed start position
// - retrace ends on five-bit end match
// - retrace skew zero to three characters
// - ten-bit vertical total is lines minus two
// - row scan presets, counts per retrace, clears
`timescale 1ns/1ps
`default_nettype none
module sqtim_top (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // host i/o port
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr_en,
  input  wire logic        io_rd_en,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_hit,
  // glyph data for the ninth dot
  input  wire logic [7:0]  glyph_code,
  input  wire logic        glyph_dot8,
  output logic             ninth_dot,
  // serializer and dot clocking
  output logic             dot_en,
  output logic             char_en,
  output logic             serial_load,
  // monitor timing
  output logic             disp_en,
  output logic             hblank,
  output logic             hretrace,
  output logic             video_blank,
  // frame position
  output logic      [9:0]  line_count,
  output logic      [4:0]  row_scan,
  output logic      [1:0]  byte_pan
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    // host-visible registers
    logic [2:0]             seq_idx;
    logic [1:0]             seq_rst;
    logic [7:0]             clk_mode;
    logic [7:0]             misc;
    logic [5:0]             crtc_idx;
    logic [sqtim_pkg::CR_COUNT-1:0][7:0] cr;
    // read answer and decode flag
    logic [7:0]             rdata;
    logic                   hit;
    // beam position counters
    logic [8:0]             hcnt;
    logic [9:0]             vcnt;
    logic [4:0]             row;
    // registered timing levels
    logic                   de;
    logic                   blank;
    logic                   ret;
    logic                   dot9;
  } sqtim_top_t;
  sqtim_top_t st_reg, st_next;

  // enables from the generator to the timing
  sqtim_clk_if ck ();

  // ************************************************************
  // decoded fields
  // ************************************************************
  // emulation select and sequencer controls
  logic        colr;
  logic        seq_arst;
  logic        seq_halt;

  // crt controller port pair
  logic [15:0] cr_index_port;
  logic [15:0] cr_data_port;

  // horizontal fields
  logic [7:0]  ht;
  logic [7:0]  hde;
  logic [7:0]  hbs;
  logic [5:0]  hbe;
  logic [7:0]  hrs;
  logic [4:0]  hre;

  // vertical fields
  logic [9:0]  vt;
  logic [4:0]  preset;
  logic [4:0]  max_scan;

  // line and frame limits
  logic [8:0]  h_last;
  logic [9:0]  v_last;
  logic        line_end;
  logic        ret_rise;

  // skewed levels and index
  logic        de_skew;
  logic        ret_skew;
  logic [4:0]  cidx;

  // ************************************************************
  // port decode and sequencer control
  // ************************************************************
  // register port pair moves with the emulation select
  assign colr = st_reg.misc[sqtim_pkg::MISC_COLR_BIT];
  assign cr_index_port = colr ? sqtim_pkg::CRTC_COLR_INDEX :
                                sqtim_pkg::CRTC_MONO_INDEX;
  assign cr_data_port  = colr ? sqtim_pkg::CRTC_COLR_DATA :
                                sqtim_pkg::CRTC_MONO_DATA;
  assign cidx = st_reg.crtc_idx[4:0];

  // any zero among the two control bits keeps the sequencer halted
  assign seq_arst = rst | ~st_reg.seq_rst[sqtim_pkg::RST_ASYNC_BIT];
  assign seq_halt = ~st_reg.seq_rst[sqtim_pkg::RST_SYNC_BIT];

  // ************************************************************
  // crt controller fields
  // ************************************************************
  // timing fields
  assign ht  = st_reg.cr[sqtim_pkg::CR_HTOTAL];
  assign hde = st_reg.cr[sqtim_pkg::CR_HDISP_END];
  assign hbs = st_reg.cr[sqtim_pkg::CR_HBLANK_ST];
  // blanking end spans two registers
  assign hbe = {st_reg.cr[sqtim_pkg::CR_HRET_END][sqtim_pkg::HRE_HBE5_BIT],
                st_reg.cr[sqtim_pkg::CR_HBLANK_END][4:0]};
  assign hrs = st_reg.cr[sqtim_pkg::CR_HRET_ST];
  assign hre = st_reg.cr[sqtim_pkg::CR_HRET_END][4:0];
  // vertical total spans the overflow register
  assign vt  = {st_reg.cr[sqtim_pkg::CR_OVERFLOW][sqtim_pkg::OV_VT9_BIT],
                st_reg.cr[sqtim_pkg::CR_OVERFLOW][sqtim_pkg::OV_VT8_BIT],
                st_reg.cr[sqtim_pkg::CR_VTOTAL]};

  // row scan and panning fields
  assign preset   = st_reg.cr[sqtim_pkg::CR_ROW_PRESET][4:0];
  assign max_scan = st_reg.cr[sqtim_pkg::CR_MAX_SCAN][4:0];
  assign byte_pan = st_reg.cr[sqtim_pkg::CR_ROW_PRESET][6:5];

  // ************************************************************
  // line and frame limits
  // ************************************************************
  // period is programmed value plus five, so last count is plus four
  assign h_last   = {1'b0, ht} + sqtim_pkg::HTOTAL_ADJ;
  assign v_last   = vt + sqtim_pkg::VTOTAL_ADJ;
  // a line ends on the character clock of the last count
  assign line_end = ck.char_en & (st_reg.hcnt == h_last);
  // retrace start also steps the row scan counter
  assign ret_rise = ck.char_en & ~st_reg.ret & (st_reg.hcnt == {1'b0, hrs});

  // ************************************************************
  // sequencer clock generator
  // ************************************************************
  // halts come from the control register bits
  sqtim_dotgen u_dotgen (
    .mclk      (mclk),
    .arst      (seq_arst),
    .sync_halt (seq_halt),
    .eight_dot (st_reg.clk_mode[sqtim_pkg::CM_EIGHT_BIT]),
    .half_dot  (st_reg.clk_mode[sqtim_pkg::CM_HALF_BIT]),
    .load2     (st_reg.clk_mode[sqtim_pkg::CM_LOAD2_BIT]),
    .load4     (st_reg.clk_mode[sqtim_pkg::CM_LOAD4_BIT]),
    .ck        (ck.gen)
  );

  // ************************************************************
  // skew of display enable and retrace
  // ************************************************************
  // display enable delay
  sqtim_skew #(.DEPTH(3)) u_de_skew (
    .mclk (mclk),
    .rst  (rst),
    .adv  (ck.char_en),
    .skew (st_reg.cr[sqtim_pkg::CR_HBLANK_END][6:5]),
    .d    (st_reg.de),
    .q    (de_skew)
  );

  // retrace delay
  sqtim_skew #(.DEPTH(3)) u_ret_skew (
    .mclk (mclk),
    .rst  (rst),
    .adv  (ck.char_en),
    .skew (st_reg.cr[sqtim_pkg::CR_HRET_END][6:5]),
    .d    (st_reg.ret),
    .q    (ret_skew)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    // hold by default; the decode flag lives one cycle
    st_next     = st_reg;
    st_next.hit = 1'b0;

    // host writes; the index ports store only implemented bits
    if (io_wr_en) begin
      if (io_addr == sqtim_pkg::SEQ_INDEX_PORT) begin
        st_next.seq_idx = io_wdata[2:0];
      end else if (io_addr == sqtim_pkg::SEQ_DATA_PORT) begin
        if (st_reg.seq_idx == sqtim_pkg::SEQ_IX_RESET) begin
          st_next.seq_rst = io_wdata[1:0];
        end else if (st_reg.seq_idx == sqtim_pkg::SEQ_IX_CLK_MODE) begin
          st_next.clk_mode = io_wdata & sqtim_pkg::CM_MASK;
        end
      end else if (io_addr == sqtim_pkg::MISC_WR_PORT) begin
        st_next.misc = io_wdata;
      end else if (io_addr == cr_index_port) begin
        st_next.crtc_idx = io_wdata[5:0];
      end else if (io_addr == cr_data_port) begin
        if (cidx < 5'(sqtim_pkg::CR_COUNT)) begin
          st_next.cr[cidx] = io_wdata;
        end
      end
    end

    // host reads; answer lands in the following cycle
    if (io_rd_en) begin
      st_next.rdata = 8'h00;
      st_next.hit   = 1'b1;
      if (io_addr == sqtim_pkg::SEQ_INDEX_PORT) begin
        st_next.rdata = {5'h00, st_reg.seq_idx};
      end else if (io_addr == sqtim_pkg::SEQ_DATA_PORT) begin
        if (st_reg.seq_idx == sqtim_pkg::SEQ_IX_RESET) begin
          st_next.rdata = {6'h00, st_reg.seq_rst};
        end else if (st_reg.seq_idx == sqtim_pkg::SEQ_IX_CLK_MODE) begin
          st_next.rdata = st_reg.clk_mode;
        end
      end else if (io_addr == sqtim_pkg::MISC_RD_PORT) begin
        st_next.rdata = st_reg.misc;
      end else if (io_addr == cr_index_port) begin
        st_next.rdata = {2'h0, st_reg.crtc_idx};
      end else if (io_addr == cr_data_port) begin
        if (cidx < 5'(sqtim_pkg::CR_COUNT)) begin
          st_next.rdata = st_reg.cr[cidx];
        end
      end else begin
        st_next.hit = 1'b0; // not ours; another decoder answers
      end
    end

    // horizontal timing advances one step per character clock
    if (ck.char_en) begin
      st_next.hcnt = line_end ? 9'h000 : st_reg.hcnt + 9'h001;
      // display enable covers counts zero through the end field
      if (line_end) begin
        st_next.de = 1'b1;
      end else if (st_reg.hcnt == {1'b0, hde}) begin
        st_next.de = 1'b0;
      end

      // start match wins; the blanking end match counts only once blanking has begun
      if (st_reg.hcnt == {1'b0, hbs}) begin
        st_next.blank = 1'b1;
      end else if (st_reg.blank && st_reg.hcnt[5:0] == hbe) begin
        st_next.blank = 1'b0;
      end

      // retrace end match likewise waits for its start
      if (st_reg.hcnt == {1'b0, hrs}) begin
        st_next.ret = 1'b1;
      end else if (st_reg.ret && st_reg.hcnt[4:0] == hre) begin
        st_next.ret = 1'b0;
      end
    end

    // vertical line counter wraps after total plus two lines
    if (line_end) begin
      st_next.vcnt = (st_reg.vcnt == v_last) ? 10'h000 : st_reg.vcnt + 10'h001;
    end

    // row scan: preset after the frame, step per retrace, clear at max
    if (line_end && st_reg.vcnt == v_last) begin
      st_next.row = preset;
    end else if (ret_rise) begin
      st_next.row = (st_reg.row == max_scan) ? 5'h00 : st_reg.row + 5'h01;
    end

    // ninth dot repeats the eighth only for line drawing codes
    st_next.dot9 = (glyph_code >= sqtim_pkg::LINE_GFX_LO) &&
                   (glyph_code <= sqtim_pkg::LINE_GFX_HI) && glyph_dot8;
  end

  // ************************************************************
  // state register
  // ************************************************************
  // whole state in one register; host state resets too
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // host read answer
  assign io_rdata    = st_reg.rdata;
  assign io_hit      = st_reg.hit;

  // sequencer pulses
  assign dot_en      = ck.dot_en;
  assign char_en     = ck.char_en;
  assign serial_load = ck.load_en;

  // eighth-dot mode leaves the ninth dot blank
  assign ninth_dot   = st_reg.dot9 & ~st_reg.clk_mode[sqtim_pkg::CM_EIGHT_BIT];

  // monitor timing levels
  assign disp_en     = de_skew & ~st_reg.clk_mode[sqtim_pkg::CM_OFF_BIT];
  assign hblank      = st_reg.blank;
  assign hretrace    = ret_skew;
  // screen off frees memory to the host, so video must go dark
  assign video_blank = st_reg.blank | st_reg.clk_mode[sqtim_pkg::CM_OFF_BIT];

  // frame position
  assign line_count  = st_reg.vcnt;
  assign row_scan    = st_reg.row;

endmodule // sqtim_top
`default_nettype wire

//--- verification/sqtim_checker.sv
// assertion checker bound to sqtim_top
`timescale 1ns/1ps
`default_nettype none
module sqtim_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // host port
  input wire logic [15:0] io_addr,
  input wire logic        io_wr_en,
  input wire logic        io_rd_en,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_hit,
  // timing
  input wire logic        dot_en,
  input wire logic        char_en,
  input wire logic        serial_load,
  input wire logic        disp_en,
  input wire logic        hblank,
  input wire logic        video_blank
);
  logic [2:0] ix;
  logic [7:0] rs;
  logic [7:0] cm;
  logic       col;
  logic [2:0] age;
  logic [3:0] dots;
  wire        run = rs[1:0] == 2'h3;
  wire        ok  = age == 3'h7;
  wire        sw  = io_wr_en && io_addr == 16'h03c5;
  // shadow of setup, aged so checks skip the switch-over cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ix <= 3'h0;
      rs <= 8'h00;
      cm <= 8'h00;
      col <= 1'b0;
      age <= 3'h0;
      dots <= 4'h0;
    end else begin
      if (io_wr_en && io_addr == 16'h03c4) ix <= io_wdata[2:0];
      if (sw && ix == 3'h0) rs <= io_wdata;
      if (sw && ix == 3'h1) cm <= io_wdata;
      if (io_wr_en && io_addr == 16'h03c2) col <= io_wdata[0];
      age <= (sw || !run) ? 3'h0 : (ok ? age : age + 3'h1);
      dots <= (!run || char_en) ? 4'h0 : (dots + {3'h0, dot_en});
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_char_on_dot: assert property (char_en |-> dot_en)
    else $error("char pulse without dot pulse");
  a_load_on_char: assert property (serial_load |-> char_en)
    else $error("load pulse without char pulse");
  a_halted_quiet: assert property (age == 3'h0 && $past(!run) && !run |-> !dot_en && !char_en)
    else $error("pulses while halted");
  a_full_rate: assert property (ok && run && !cm[3] |-> dot_en)
    else $error("dot pulse missing");
  a_half_rate: assert property (ok && run && cm[3] |-> dot_en != $past(dot_en))
    else $error("half rate dots not alternating");
  a_char_width: assert property (ok && char_en |-> dots == (cm[0] ? 4'h7 : 4'h8))
    else $error("wrong dots per char");
  a_screen_off: assert property (ok && cm[5] |-> !disp_en && video_blank)
    else $error("screen not off");
  a_blank_follow: assert property (ok && !cm[5] |-> video_blank == hblank)
    else $error("video blank differs from hblank");
  a_crtc_decode: assert property (io_rd_en && io_addr == (col ? 16'h03d4 : 16'h03b4) |=> io_hit)
    else $error("active crtc pair not decoded");
  a_crtc_ignore: assert property (io_rd_en && io_addr == (col ? 16'h03b4 : 16'h03d4) |=> !io_hit)
    else $error("inactive crtc pair decoded");
endmodule // sqtim_checker
bind sqtim_top sqtim_checker chk (.mclk, .rst, .io_addr, .io_wr_en, .io_rd_en, .io_wdata,
  .io_hit, .dot_en, .char_en, .serial_load, .disp_en, .hblank, .video_blank);
`default_nettype wire

//--- verification/sqtim_monitor.sv
// monitor model measuring line timing in character clocks
`timescale 1ns/1ps
`default_nettype none
module sqtim_monitor (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // timing from the block
  input wire logic       char_en,
  input wire logic       hretrace,
  input wire logic       disp_en,
  input wire logic       hblank,
  // measurements
  output logic [7:0]     period,
  output logic [7:0]     de_off,
  output logic [2:0][7:0] wid
);
  logic [2:0]      sq;
  logic [2:0][7:0] acc;
  logic [7:0]      pc;
  wire  [2:0]      s = {hblank, disp_en, hretrace};
  // sample once per char; widths latch on falls, period on retrace rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sq <= 3'h0;
      acc <= '0;
      wid <= '0;
      pc <= 8'h00;
      period <= 8'h00;
      de_off <= 8'h00;
    end else if (char_en) begin
      sq <= s;
      pc <= (s[0] && !sq[0]) ? 8'h01 : pc + 8'h01;
      if (s[0] && !sq[0]) period <= pc;
      if (s[1] && !sq[1]) de_off <= pc;
      for (int i = 0; i < 3; i++) begin
        acc[i] <= s[i] ? acc[i] + 8'h01 : 8'h00;
        if (!s[i] && sq[i]) wid[i] <= acc[i];
      end
    end
  end
endmodule // sqtim_monitor
`default_nettype wire

//--- verification/tb.sv
// self-checking testbench for sqtim_top
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr_en = 1'b0;
  logic        io_rd_en = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  glyph_code = 8'h00;
  logic        glyph_dot8 = 1'b0;
  logic [7:0]  io_rdata;
  logic        io_hit, ninth_dot, dot_en, char_en, serial_load;
  logic        disp_en, hblank, hretrace, video_blank;
  logic [9:0]  line_count;
  logic [4:0]  row_scan;
  logic [1:0]  byte_pan;
  logic [7:0]  period, de_off;
  logic [2:0][7:0] wid;
  logic [15:0] nd, nc, nl, ml, mr, pl, o0;
  logic [7:0]  m;
  logic [7:0]  modes [6] = '{8'h01, 8'h00, 8'h09, 8'h05, 8'h15, 8'h11};
  logic [7:0]  codes [4] = '{8'hc0, 8'hdf, 8'hbf, 8'he0};
  int          error_cnt = 0;
  int          comparisons = 0;
  sqtim_top dut (.mclk, .rst, .io_addr, .io_wr_en, .io_rd_en, .io_wdata, .io_rdata, .io_hit,
    .glyph_code, .glyph_dot8, .ninth_dot, .dot_en, .char_en, .serial_load, .disp_en,
    .hblank, .hretrace, .video_blank, .line_count, .row_scan, .byte_pan);
  sqtim_monitor mon (.mclk, .rst, .char_en, .hretrace, .disp_en, .hblank, .period,
    .de_off, .wid);
  // 200 mhz clock
  always #2.5 mclk = ~mclk;
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one-cycle strobes, a free edge between requests
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr_en <= 1'b1;
    @(posedge mclk);
    io_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h, input string nm);
    @(posedge mclk);
    io_addr <= a;
    io_rd_en <= 1'b1;
    @(posedge mclk);
    io_rd_en <= 1'b0;
    #1;
    chk(nm, io_rdata, e);
    chk({nm, " hit"}, io_hit, h);
  endtask
  task automatic sq(input logic [2:0] i, input logic [7:0] d);
    wr(16'h03c4, {5'h00, i});
    wr(16'h03c5, d);
  endtask
  task automatic cr(input logic [4:0] i, input logic [7:0] d);
    wr(16'h03d4, {3'h0, i});
    wr(16'h03d5, d);
  endtask
  // align to a load pulse, then count pulses over 576 cycles
  task automatic meas;
    int k;
    nd = 0;
    nc = 0;
    nl = 0;
    k = 0;
    #1;
    while (serial_load !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    for (int i = 0; i < 576; i++) begin
      @(posedge mclk);
      #1;
      nd += dot_en;
      nc += char_en;
      nl += serial_load;
    end
  endtask
  // watchdog
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    wr(16'h03c4, 8'h00);
    rd(16'h03c5, 8'h00, 1'b1, "reset reg");
    rd(16'h03c0, 8'h00, 1'b0, "unmapped");
    meas();
    chk("halted dots", nd, 16'h0000);
    sq(3'h1, 8'h01);
    sq(3'h0, 8'h03);
    sq(3'h0, 8'h02);
    meas();
    chk("async halt", nd, 16'h0000);
    sq(3'h0, 8'h03);
    sq(3'h0, 8'h01);
    meas();
    chk("sync halt", nd, 16'h0000);
    for (int j = 0; j < 6; j++) begin
      m = modes[j];
      sq(3'h0, 8'h01);
      sq(3'h1, m | 8'hc2);
      rd(16'h03c5, m, 1'b1, "clk mode");
      sq(3'h0, 8'h03);
      meas();
      o0 = m[3] ? 16'h0120 : 16'h0240;
      chk("dots", nd, o0);
      o0 = o0 / (m[0] ? 16'h0008 : 16'h0009);
      chk("chars", nc, o0);
      chk("loads", nl, o0 / (m[4] ? 16'h0004 : (m[2] ? 16'h0002 : 16'h0001)));
    end
    wr(16'h03c2, 8'h01);
    rd(16'h03b4, 8'h00, 1'b0, "mono index");
    cr(5'h00, 8'h05);
    cr(5'h01, 8'h05);
    cr(5'h02, 8'h07);
    cr(5'h03, 8'h09);
    cr(5'h04, 8'h06);
    cr(5'h05, 8'h08);
    rd(16'h03d5, 8'h08, 1'b1, "crtc data");
    rd(16'h03d4, 8'h05, 1'b1, "crtc index");
    repeat (400) @(posedge mclk);
    chk("period", period, 16'h000a);
    chk("de width", wid[1], 16'h0006);
    chk("blank width", wid[2], 16'h0002);
    chk("retrace width", wid[0], 16'h0002);
    o0 = de_off % 8'h0a;
    cr(5'h03, 8'h49);
    cr(5'h05, 8'h28);
    repeat (400) @(posedge mclk);
    chk("skew", de_off % 8'h0a, (o0 + 16'h0001) % 16'h000a);
    chk("skewed de width", wid[1], 16'h0006);
    sq(3'h1, 8'h21);
    nd = 0;
    repeat (20) @(posedge mclk);
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk);
      #1;
      nd += disp_en;
    end
    chk("screen off", nd, 16'h0000);
    sq(3'h1, 8'h01);
    cr(5'h06, 8'h03);
    cr(5'h07, 8'h00);
    cr(5'h09, 8'h02);
    cr(5'h08, 8'h41);
    #1;
    chk("byte pan", byte_pan, 16'h0002);
    ml = 0;
    mr = 0;
    pl = 0;
    for (int i = 0; i < 1600; i++) begin
      @(posedge mclk);
      #1;
      if (line_count > ml) ml = line_count;
      if (row_scan > mr) mr = row_scan;
      if (line_count == 10'h000 && pl != 16'h0000) chk("preset", row_scan, 16'h0001);
      pl = line_count;
    end
    chk("last line", ml, 16'h0004);
    chk("max row", mr, 16'h0002);
    sq(3'h0, 8'h01);
    sq(3'h1, 8'h00);
    sq(3'h0, 8'h03);
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk);
      glyph_code <= codes[j];
      glyph_dot8 <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk("ninth dot", ninth_dot, {15'h0000, j < 2});
    end
    sq(3'h0, 8'h01);
    sq(3'h1, 8'h01);
    @(posedge mclk);
    glyph_code <= 8'hc0;
    repeat (2) @(posedge mclk);
    #1;
    chk("eight dot ninth", ninth_dot, 16'h0000);
    test_done();
  end
endmodule // tb
`default_nettype wire
